// file: rtl/wgs_steer.sv
// Functional notes
// - Clock select bit 0 clear clocks the generator from the system oscillator.
// - Clock select set uses fast internal oscillator, which keeps running in sleep.
// - Four-bit input source field in low bits of data select register.
// - Source codes map pin, comparators, capture units, pulse units, oscillator, cells.
// - Unused upper bits of clock and data select registers read zero.
// - Steer enable set passes polarity-adjusted data input to that output.
// - In either steering mode, steer enable clear forces output to its override bit, bits 7..4.
// - Each of the four outputs has its own steering enable bit.
// - In synchronous steering mode the steering enables are double-buffered.
`timescale 1ns/100ps
`default_nettype none
`include "wgs_defs.svh"

module wgs_steer (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            sys_osc_tick,
    input  wire logic            fast_osc_tick,
    input  wire logic            sleep_mode,
    input  wire wgs_pkg::wgs_src_t src,
    output logic                 generator_output_a,
    output logic                 generator_output_b,
    output logic                 generator_output_c,
    output logic                 generator_output_d,
    output logic                 data_input_level
);
    import wgs_pkg::*;

    wgs_state_t st_q;
    wgs_state_t st_d;
    logic       gen_tick;
    logic       data_now;
    logic       steering;
    logic       sync_mode;
    logic       din_rise;
    logic [3:0] en_eff;
    logic [3:0] out_calc;

    // ****************************************************************
    // Generator clock enable
    // ****************************************************************

    // oscillator select path
    // System oscillator stops in sleep, the fast one keeps ticking
    assign gen_tick = st_q.clk_sel ? fast_osc_tick
                                   : (sys_osc_tick & ~sleep_mode);

    // ****************************************************************
    // Data input selection
    // ****************************************************************

    // source code mapping
    // Reserved codes feed a constant low
    always_comb begin
        if (st_q.src_sel == `WGS_SRC_PIN) begin
            data_now = src.remapped_pin_input;
        end else if (st_q.src_sel == `WGS_SRC_CMP1) begin
            data_now = src.comparator_one_result;
        end else if (st_q.src_sel == `WGS_SRC_CMP2) begin
            data_now = src.comparator_two_result;
        end else if (st_q.src_sel == `WGS_SRC_CCU1) begin
            data_now = src.capture_compare_unit_one;
        end else if (st_q.src_sel == `WGS_SRC_CCU2) begin
            data_now = src.capture_compare_unit_two;
        end else if (st_q.src_sel == `WGS_SRC_PWU5) begin
            data_now = src.pulse_width_unit_five;
        end else if (st_q.src_sel == `WGS_SRC_PWU6) begin
            data_now = src.pulse_width_unit_six;
        end else if (st_q.src_sel == `WGS_SRC_NCO) begin
            data_now = src.numeric_oscillator_out;
        end else if (st_q.src_sel == `WGS_SRC_LC1) begin
            data_now = src.logic_cell_one_out;
        end else if (st_q.src_sel == `WGS_SRC_LC2) begin
            data_now = src.logic_cell_two_out;
        end else begin
            data_now = 1'b0;
        end
    end

    // ****************************************************************
    // Steering
    // ****************************************************************

    // Mode decode and data edge seen at a generator tick
    assign sync_mode = (st_q.mode == `WGS_MODE_SYNC);
    assign steering  = (st_q.mode == `WGS_MODE_ASYNC) | sync_mode;
    assign din_rise  = gen_tick & data_now & ~st_q.din;

    // buffered enables
    // In sync mode the held value is used until a data rising edge
    assign en_eff = !sync_mode ? st_q.steer[3:0]
                  : (din_rise ? st_q.steer[3:0] : st_q.steer_act);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_out
            assign out_calc[gi] = (!steering || en_eff[gi])
                                ? (data_now ^ st_q.pol[gi])
                                : st_q.steer[4 + gi];
        end
    endgenerate

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Bus slave, register writes and output update
    always_comb begin
        st_d       = st_q;
        st_d.ready = 1'b0;
        st_d.err   = 1'b0;
        if (!sync_mode) begin
            st_d.steer_act = st_q.steer[3:0];
        end else if (din_rise) begin
            st_d.steer_act = st_q.steer[3:0];
        end
        if (gen_tick) begin
            st_d.din  = data_now;
            st_d.outs = out_calc;
        end
        // Setup phase: decode and prepare the answer
        if (psel && !penable) begin
            st_d.ready = 1'b1;
            st_d.rdata = 32'h0000_0000;
            if (paddr == `WGS_OFS_CLKSEL) begin
                st_d.rdata[0] = st_q.clk_sel;
            end else if (paddr == `WGS_OFS_DATSEL) begin
                st_d.rdata[3:0] = st_q.src_sel;
            end else if (paddr == `WGS_OFS_STEER) begin
                st_d.rdata[7:0] = st_q.steer;
            end else if (paddr == `WGS_OFS_MODEPOL) begin
                st_d.rdata[`WGS_POS_MODE +: 3] = st_q.mode;
                st_d.rdata[`WGS_POS_POL +: 4]  = st_q.pol;
                st_d.rdata[`WGS_POS_DIN]       = st_q.din;
            end else begin
                st_d.err = 1'b1;
            end
        end
        // Access phase: the write lands on the completing edge
        if (psel && penable && st_q.ready && pwrite && !st_q.err) begin
            if (paddr == `WGS_OFS_CLKSEL) begin
                st_d.clk_sel = pwdata[0];
            end else if (paddr == `WGS_OFS_DATSEL) begin
                st_d.src_sel = pwdata[3:0];
            end else if (paddr == `WGS_OFS_STEER) begin
                st_d.steer = pwdata[7:0];
            end else if (paddr == `WGS_OFS_MODEPOL) begin
                st_d.mode = pwdata[`WGS_POS_MODE +: 3];
                st_d.pol  = pwdata[`WGS_POS_POL +: 4];
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q           <= '0;
            st_q.clk_sel   <= `WGS_RST_CLKSEL;
            st_q.src_sel   <= `WGS_RST_DATSEL;
            st_q.steer     <= `WGS_RST_STEER;
            st_q.steer_act <= `WGS_RST_STEER_ACT;
            st_q.mode      <= `WGS_RST_MODE;
            st_q.pol       <= `WGS_RST_POL;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // All outputs straight from the state register
    assign prdata             = st_q.rdata;
    assign pready             = st_q.ready;
    assign pslverr            = st_q.err;
    assign generator_output_a = st_q.outs[0];
    assign generator_output_b = st_q.outs[1];
    assign generator_output_c = st_q.outs[2];
    assign generator_output_d = st_q.outs[3];
    assign data_input_level   = st_q.din;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Read of the clock select register, setup then access
    sequence s_rd_clksel;
        psel && !penable && !pwrite && paddr == `WGS_OFS_CLKSEL ##1
        psel && penable;
    endsequence

    // Read of the data select register, setup then access
    sequence s_rd_datsel;
        psel && !penable && !pwrite && paddr == `WGS_OFS_DATSEL ##1
        psel && penable;
    endsequence

    a_sys_clk_sleep: assert property (
        !st_q.clk_sel && sleep_mode && st_q.clk_sel == st_d.clk_sel
        |=> $stable(st_q.outs) && $stable(st_q.din))
        else $error("outputs moved while system clock stopped");

    a_fast_clk_sleep: assert property (
        st_q.clk_sel && fast_osc_tick && sleep_mode
        |=> st_q.din == $past(data_now))
        else $error("fast clock did not run in sleep");

    a_src_decode: assert property (
        st_q.src_sel == `WGS_SRC_CMP1 |-> data_now == src.comparator_one_result)
        else $error("source code one not comparator one");

    a_src_reserved: assert property (
        st_q.src_sel > `WGS_SRC_LC2 |-> !data_now)
        else $error("reserved source not low");

    a_upper_zero: assert property (
        (s_rd_clksel |-> prdata[31:1] == 31'h0 && pready) and
        (s_rd_datsel |-> prdata[31:4] == 28'h0 && pready))
        else $error("unused bits not zero");

    a_steer_data: assert property (
        gen_tick && st_q.mode == `WGS_MODE_ASYNC && st_q.steer[3:0] == 4'hf
        |=> st_q.outs == ($past({4{data_now}}) ^ $past(st_q.pol)))
        else $error("steered output wrong");

    a_override_val: assert property (
        gen_tick && steering && en_eff == 4'h0
        |=> st_q.outs == $past(st_q.steer[7:4]))
        else $error("override value not driven");

    a_indep_bits: assert property (
        gen_tick && st_q.mode == `WGS_MODE_ASYNC && st_q.steer[3:0] == 4'h5
        |=> st_q.outs[3] == $past(st_q.steer[7])
            && st_q.outs[0] == $past(data_now ^ st_q.pol[0]))
        else $error("outputs not independent");

    a_non_steer: assert property (
        gen_tick && !steering
        |=> st_q.outs == ($past({4{data_now}}) ^ $past(st_q.pol)))
        else $error("steering used outside steering modes");

    a_sync_hold: assert property (
        sync_mode && !din_rise ##1 sync_mode
        |-> $stable(st_q.steer_act))
        else $error("buffered enables changed without edge");

    a_async_next: assert property (
        gen_tick && st_q.mode == `WGS_MODE_ASYNC && st_q.steer[3:0] == 4'h0
        ##1 st_q.mode == `WGS_MODE_ASYNC && st_q.steer[3:0] == 4'h0
        |-> st_q.outs == $past(st_q.steer[7:4]))
        else $error("async change not on next tick");

    a_sync_load: assert property (
        sync_mode && din_rise
        |=> st_q.steer_act == $past(st_q.steer[3:0]))
        else $error("buffered enables not loaded on data edge");

    // middle reserved codes give low input
    a_src_rsv_mid: assert property (
        (st_q.src_sel == `WGS_SRC_RSV5 || st_q.src_sel == `WGS_SRC_RSV6) |-> !data_now)
        else $error("middle reserved source not low");

    // polarity applied in both steering modes
    a_pol_invert: assert property (
        gen_tick && steering && en_eff == 4'hf
        |=> st_q.outs == $past({4{data_now}} ^ st_q.pol))
        else $error("steered polarity wrong");

    a_tick_hold: assert property (!gen_tick |=> $stable(st_q.outs))
        else $error("outputs moved without a generator tick");

endmodule

`default_nettype wire

// file: rtl/wgs_defs.svh
`ifndef WGS_DEFS_SVH
`define WGS_DEFS_SVH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define WGS_OFS_CLKSEL  12'h000
`define WGS_OFS_DATSEL  12'h004
`define WGS_OFS_STEER   12'h008
`define WGS_OFS_MODEPOL 12'h00c

// ********************************************************************
// Reset values and field positions
// ********************************************************************
`define WGS_RST_CLKSEL  1'h0
`define WGS_RST_DATSEL  4'h0
`define WGS_RST_STEER   8'h00
`define WGS_RST_STEER_ACT 4'h0
`define WGS_RST_MODE    3'h0
`define WGS_RST_POL     4'h0
`define WGS_POS_MODE    0
`define WGS_POS_POL     8
`define WGS_POS_DIN     16

// ********************************************************************
// Mode codes
// ********************************************************************
`define WGS_MODE_ASYNC  3'h0
`define WGS_MODE_SYNC   3'h1

// ********************************************************************
// Data input source codes
// ********************************************************************
`define WGS_SRC_PIN     4'h0
`define WGS_SRC_CMP1    4'h1
`define WGS_SRC_CMP2    4'h2
`define WGS_SRC_CCU1    4'h3
`define WGS_SRC_CCU2    4'h4
`define WGS_SRC_PWU5    4'h7
`define WGS_SRC_PWU6    4'h8
`define WGS_SRC_NCO     4'h9
`define WGS_SRC_LC1     4'ha
`define WGS_SRC_LC2     4'hb
`define WGS_SRC_RSV5    4'h5
`define WGS_SRC_RSV6    4'h6

`endif

// file: rtl/wgs_pkg.sv
`include "wgs_defs.svh"

package wgs_pkg;

    // Candidate data input signals
    typedef struct packed {
        logic remapped_pin_input;
        logic comparator_one_result;
        logic comparator_two_result;
        logic capture_compare_unit_one;
        logic capture_compare_unit_two;
        logic pulse_width_unit_five;
        logic pulse_width_unit_six;
        logic numeric_oscillator_out;
        logic logic_cell_one_out;
        logic logic_cell_two_out;
    } wgs_src_t;

    // Whole state of the block
    typedef struct packed {
        logic        clk_sel;
        logic [3:0]  src_sel;
        logic [7:0]  steer;
        logic [3:0]  steer_act;
        logic [2:0]  mode;
        logic [3:0]  pol;
        logic        din;
        logic [3:0]  outs;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
    } wgs_state_t;

endpackage

// file: test/wgs_src_model.sv
`timescale 1ns/100ps
`default_nettype none

module wgs_src_model (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic [9:0]     pat,
    output var wgs_pkg::wgs_src_t src
);
    import wgs_pkg::*;

    // Peripheral outputs move just after the clock, like on-chip logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src <= '0;
        end else begin
            src <= wgs_src_t'(pat);
        end
    end
endmodule

`default_nettype wire

// file: test/wgs_steer_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "wgs_defs.svh"

module wgs_steer_tb;
    import wgs_pkg::*;

    // ********************************************************************
    // Signals and bookkeeping
    // ********************************************************************
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        sys_osc_tick, fast_osc_tick, sleep_mode, obs;
    logic        out_a, out_b, out_c, out_d, din_lvl;
    wgs_src_t    src;
    logic [9:0]  pat, p, oh;
    logic [7:0]  st;
    logic [3:0]  pol;
    logic [4:0]  last;
    logic [32:0] rexp;
    logic [32:0] rq[$];
    logic [4:0]  oq[$];
    int          errors, checks, seed;
    localparam int MAP[16] = '{9, 8, 7, 6, 5, -1, -1, 4, 3, 2, 1, 0, -1, -1, -1, -1};

    wgs_src_model peer (.pclk(pclk), .presetn(presetn), .pat(pat), .src(src));

    wgs_steer dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sys_osc_tick(sys_osc_tick),
        .fast_osc_tick(fast_osc_tick), .sleep_mode(sleep_mode), .src(src),
        .generator_output_a(out_a), .generator_output_b(out_b),
        .generator_output_c(out_c), .generator_output_d(out_d),
        .data_input_level(din_lvl)
    );

    // Clock
    always #12.5 pclk = ~pclk;

    // ********************************************************************
    // Tasks and functions
    // ********************************************************************
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One APB transfer; the monitor compares the answer with e
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        rq.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 50);
        if (n >= 50) errors++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic setmode(input logic [2:0] m);
        apb(1'b1, `WGS_OFS_MODEPOL, {20'h0, pol, 5'h0, m}, 33'h0);
    endtask

    // Present a source pattern, pulse the oscillator ticks, note the outcome
    task automatic step(input logic [9:0] pv, input logic f, input logic s,
                        input logic [4:0] e);
        pat <= pv;
        repeat (2) @(posedge pclk);
        oq.push_back(e);
        fast_osc_tick <= f;
        sys_osc_tick <= s;
        @(posedge pclk);
        fast_osc_tick <= 1'b0;
        sys_osc_tick <= 1'b0;
        obs <= 1'b1;
        @(posedge pclk);
        obs <= 1'b0;
        last = e;
    endtask

    function automatic logic dat(input int c, input logic [9:0] pv);
        return (MAP[c] < 0) ? 1'b0 : pv[MAP[c]];
    endfunction

    // Expected {data, d, c, b, a} for steering byte and polarity
    function automatic logic [4:0] expo(input logic d, input logic [7:0] s,
                                        input logic [3:0] pl);
        logic [3:0] o;
        for (int i = 0; i < 4; i++) o[i] = s[i] ? d ^ pl[i] : s[i+4];
        return {d, o};
    endfunction

    // Monitor: compares every answer with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            rexp = rq.pop_front();
            if (pwrite) check({pslverr, 32'h0}, {rexp[32], 32'h0});
            else check({pslverr, prdata}, rexp);
        end
        if (obs) check({28'h0, din_lvl, out_d, out_c, out_b, out_a}, {28'h0, oq.pop_front()});
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        report_and_stop();
    end

    // ********************************************************************
    // Main sequence
    // ********************************************************************
    initial begin
        {pclk, presetn, psel, penable, pwrite, sys_osc_tick, fast_osc_tick} = '0;
        {sleep_mode, obs, paddr, pwdata, pat} = '0;
        errors = 0;
        checks = 0;
        seed = 44498;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) apb(1'b0, 12'(i * 4), 32'h0, 33'h0);
        apb(1'b1, 12'h010, 32'hffffffff, {1'b1, 32'h0});
        apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
        apb(1'b1, `WGS_OFS_CLKSEL, 32'hffffffff, 33'h0);
        apb(1'b0, `WGS_OFS_CLKSEL, 32'h0, 33'h1);
        apb(1'b1, `WGS_OFS_CLKSEL, 32'h0, 33'h0);
        apb(1'b1, `WGS_OFS_DATSEL, 32'hffffffff, 33'h0);
        apb(1'b0, `WGS_OFS_DATSEL, 32'h0, 33'hf);
        apb(1'b1, `WGS_OFS_STEER, 32'h0f, 33'h0);
        apb(1'b0, `WGS_OFS_STEER, 32'h0, 33'h0f);
        pol = 4'b0101;
        setmode(`WGS_MODE_ASYNC);
        apb(1'b0, `WGS_OFS_MODEPOL, 32'h0, 33'h500);
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, `WGS_OFS_DATSEL, 32'(c), 33'h0);
            oh = (MAP[c] < 0) ? 10'h0 : (10'h1 << MAP[c]);
            for (int k = 0; k < 2; k++) begin
                p = k ? ~oh : oh;
                step(p, 1'b0, 1'b1, expo(dat(c, p), 8'h0f, pol));
            end
        end
        apb(1'b1, `WGS_OFS_DATSEL, 32'h1, 33'h0);
        // Fixed mixes: two steered and two overridden, then all overridden
        apb(1'b1, `WGS_OFS_STEER, 32'h85, 33'h0);
        step(10'h100, 1'b0, 1'b1, expo(1'b1, 8'h85, pol));
        apb(1'b1, `WGS_OFS_STEER, 32'h90, 33'h0);
        step(10'h000, 1'b0, 1'b1, expo(1'b0, 8'h90, pol));
        repeat (8) begin
            st = 8'($random(seed));
            p = 10'($random(seed));
            apb(1'b1, `WGS_OFS_STEER, {24'h0, st}, 33'h0);
            step(p, 1'b0, 1'b1, expo(p[8], st, pol));
        end
        for (int m = 2; m < 8; m++) begin
            setmode(3'(m));
            p = 10'($random(seed));
            step(p, 1'b0, 1'b1, expo(p[8], 8'h0f, pol));
        end
        setmode(`WGS_MODE_ASYNC);
        apb(1'b1, `WGS_OFS_STEER, 32'h0f, 33'h0);
        step(10'h100, 1'b0, 1'b1, expo(1'b1, 8'h0f, pol));
        sleep_mode <= 1'b1;
        step(10'h000, 1'b0, 1'b1, last);
        step(10'h000, 1'b1, 1'b0, last);
        apb(1'b1, `WGS_OFS_CLKSEL, 32'h1, 33'h0);
        step(10'h000, 1'b0, 1'b1, last);
        step(10'h000, 1'b1, 1'b0, expo(1'b0, 8'h0f, pol));
        sleep_mode <= 1'b0;
        apb(1'b1, `WGS_OFS_CLKSEL, 32'h0, 33'h0);
        pol = 4'h0;
        setmode(`WGS_MODE_SYNC);
        step(10'h3ff, 1'b0, 1'b1, 5'h1f);
        apb(1'b1, `WGS_OFS_STEER, 32'hf0, 33'h0);
        step(10'h000, 1'b0, 1'b1, 5'h00);
        step(10'h3ff, 1'b0, 1'b1, 5'h1f);
        step(10'h000, 1'b0, 1'b1, 5'h0f);
        report_and_stop();
    end
endmodule

`default_nettype wire
